//--- hdl/touch_cfg_pkg.sv
// Constants, field layouts and carriers for the touch global configuration bank.
// Assumes a single 250 MHz clock domain and a plain strobe register port.
package touch_cfg_pkg;

   // ----------------------------------------------------------------------
   // Register offsets and reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_TOUCH_GAIN_CTRL    = 8'h1f;
   localparam logic [7:0] ADDR_GLOBAL_CONFIG      = 8'h20;
   localparam logic [7:0] ADDR_GLOBAL_CONFIG_SEC  = 8'h44;
   localparam logic [7:0] ADDR_GLOBAL_STATUS      = 8'h02;
   localparam logic [7:0] RST_TOUCH_GAIN_CTRL     = 8'h2f;
   localparam logic [7:0] RST_GLOBAL_CONFIG       = 8'h20;
   localparam logic [7:0] RST_GLOBAL_CONFIG_SEC   = 8'h40;
   localparam logic [7:0] MASK_GLOBAL_CONFIG      = 8'hb8;
   localparam logic [7:0] MASK_GLOBAL_CONFIG_SEC  = 8'h7f;
   localparam logic [7:0] MASK_TOUCH_GAIN_CTRL    = 8'h7f;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int GAIN_LSB        = 4;
   localparam int SHIFT_LSB       = 0;
   localparam int CFG_STALL_EN    = 7;
   localparam int CFG_DIG_OFF     = 5;
   localparam int CFG_LF_OFF      = 4;
   localparam int CFG_LONG_EN     = 3;
   localparam int CF2_RETRY       = 6;
   localparam int CF2_PWR_HOLD    = 5;
   localparam int CF2_LIMIT_IRQ   = 4;
   localparam int CF2_RF_ONLY     = 3;
   localparam int CF2_RF_OFF      = 2;
   localparam int CF2_CAL_IRQ     = 1;
   localparam int CF2_REL_SUP     = 0;
   localparam int STAT_LIMIT_BIT  = 6;
   localparam int STAT_CAL_BIT    = 5;
   localparam logic [3:0] SHIFT_MAX_CODE = 4'h8;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_PS   = 4000;
   localparam int LOW_STALL_US    = 30000;   // 30 ms
   localparam int IDLE_US         = 200;
   localparam int LOW_STALL_CYCLES = (LOW_STALL_US * 1000) / (CLK_PERIOD_PS / 1000) + 1;
   localparam int IDLE_CYCLES      = (IDLE_US * 1000) / (CLK_PERIOD_PS / 1000) + 1;
   localparam int LONG_TICK_MS    = 35;

   // Per-channel analog report
   typedef struct packed {
      logic [7:0] raw_delta;
      logic       lf_noise;
      logic       rf_noise;
      logic       above_noise_thr;
      logic       above_touch_thr;
      logic       touched;
      logic       limit_out;
      logic       calib_fail;
      logic       enabled;
   } chan_in_s;

   // Per-channel decisions back to the sensing engine
   typedef struct packed {
      logic [7:0] delta;
      logic       noise_status;
      logic       recal_feed;
      logic       long_recal;
      logic       retry_calib;
   } chan_out_s;

endpackage

//--- hdl/touch_sense_global_config.sv
// Global configuration bank of an eight-input touch controller: gain,
// base count presentation, noise blocking, recalibration and interrupt policy.
// Assumes the serial bus slave, analog engine and timers sit outside and
// report per-channel events on clk_in.
//
// Behaviour
// RULE_01 - Gain code 000 gives 128x, each step halves, 111 gives 1x; reset 32x.
// RULE_02 - Base count presented scaled by two to the power of the shift code.
// RULE_03 - Base count scaling never reaches touch detection or sensitivity.
// RULE_04 - Stall enable set: clock low beyond 30 ms resets the serial interface.
// RULE_05 - Stall enable set: both lines high beyond 200 us resets the interface.
// RULE_06 - Stall enable clear (reset): no stall or idle reset of the interface.
// RULE_07 - Digital rejection on: noise-band samples are dropped from recalibration.
// RULE_08 - Digital rejection off (reset): every sub-touch delta feeds recalibration; code still drops samples the low-frequency or RF filter blocks.
// RULE_09 - Low-frequency filter on: zero delta on low-frequency noise; off passes touches.
// RULE_10 - Long touch recalibration off (reset): touches persist, no length recalibration.
// RULE_11 - Long touch recalibration on: touch over the limit restarts recalibration.
// RULE_12 - Retry set (reset): repeat calibration on any input flagged out of limit; code repeats it for enabled inputs only.
// RULE_13 - Retry clear: keep using the out-of-limit base count, no recalibration.
// RULE_14 - Power hold clear: reduced power after last conversion; set stays full power.
// RULE_15 - Limit interrupt enable set: global limit flag rising raises an interrupt.
// RULE_16 - RF-only reporting: status shows RF noise only; low-frequency still blocks.
// RULE_17 - RF filter on: zero delta on RF noise; off lets RF noise through.
// RULE_18 - Calibration interrupt enable set: failure flag rising raises an interrupt.
// RULE_19 - Release suppress clear: interrupt on press, release and repeat.
// RULE_20 - Release suppress set: interrupt on press and repeat, none on release.
// RULE_21 - Shift codes above eight are stored and present as 256x.
// RULE_22 - Global limit flag holds while any enabled input is out of limit.
`timescale 1ns/1ps

module touch_sense_global_config
   import touch_cfg_pkg::*;
#(
   parameter int NUM_CH      = 8,
   parameter int STALL_LOW   = LOW_STALL_CYCLES,
   parameter int STALL_IDLE  = IDLE_CYCLES,
   parameter int BASE_W      = 16
) (
   // Clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    rst_b_in,
   // Register port
   input  wire logic [7:0]              reg_addr_in,
   input  wire logic [7:0]              reg_wdata_in,
   input  wire logic                    reg_wr_in,
   input  wire logic                    reg_rd_in,
   output logic      [7:0]              reg_rdata_out,
   // Serial bus lines, from pins
   input  wire logic                    bus_clk_pin_in,
   input  wire logic                    bus_data_pin_in,
   output logic                         bus_reset_out,
   // Per-channel analog reports and decisions
   input  wire chan_in_s [NUM_CH-1:0]   chan_in,
   output chan_out_s [NUM_CH-1:0]       chan_out,
   // Long touch duration limit tick (one pulse when limit exceeded per channel)
   input  wire logic [NUM_CH-1:0]       long_limit_hit_in,
   // Button events from the interrupt engine
   input  wire logic                    press_evt_in,
   input  wire logic                    release_evt_in,
   input  wire logic                    repeat_evt_in,
   // Base count presentation
   input  wire logic [BASE_W-1:0]       base_raw_in,
   output logic      [BASE_W+7:0]       base_view_out,
   // Power and interrupt request
   input  wire logic                    conv_done_in,
   input  wire logic                    cycle_end_in,
   output logic                         low_power_out,
   output logic                         irq_req_out,
   output logic                         limit_flag_out,
   output logic                         calib_flag_out
);

   // Elaboration check: flag vectors serve one to eight inputs, counters need two cycles
   if (NUM_CH < 1 || NUM_CH > 8 || STALL_LOW < 2 || STALL_IDLE < 2 || BASE_W < 1) begin : g_param_check
      $error("touch_sense_global_config: unsupported parameter");
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [7:0] gain_q, cfg_q, cf2_q;
   logic [7:0] rdata_q;

   wire sel_gain = reg_addr_in == ADDR_TOUCH_GAIN_CTRL;
   wire sel_cfg  = reg_addr_in == ADDR_GLOBAL_CONFIG;
   wire sel_cf2  = reg_addr_in == ADDR_GLOBAL_CONFIG_SEC;
   wire sel_stat = reg_addr_in == ADDR_GLOBAL_STATUS;

   // Register writes; reserved bits stay zero
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         gain_q <= RST_TOUCH_GAIN_CTRL;
         cfg_q  <= RST_GLOBAL_CONFIG;
         cf2_q  <= RST_GLOBAL_CONFIG_SEC;
      end else if (reg_wr_in) begin
         if (sel_gain)     gain_q <= reg_wdata_in & MASK_TOUCH_GAIN_CTRL; // RULE_21
         else if (sel_cfg) cfg_q  <= reg_wdata_in & MASK_GLOBAL_CONFIG;
         else if (sel_cf2) cf2_q  <= reg_wdata_in & MASK_GLOBAL_CONFIG_SEC;
      end
   end

   // Read mux; unmapped addresses read zero
   logic limit_q, calib_q;
   wire [7:0] stat_view = {1'b0, limit_q, calib_q, 5'h00};
   wire [7:0] rd_mux = sel_gain ? gain_q :
                       sel_cfg  ? cfg_q  :
                       sel_cf2  ? cf2_q  :
                       sel_stat ? stat_view : 8'h00;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) rdata_q <= 8'h00;
      else if (reg_rd_in) rdata_q <= rd_mux;
      else rdata_q <= 8'h00;
   end
   assign reg_rdata_out = rdata_q;

   // Field decode
   wire [2:0] gain_code  = gain_q[GAIN_LSB +: 3];
   wire [3:0] shift_code = gain_q[SHIFT_LSB +: 4];
   wire stall_en   = cfg_q[CFG_STALL_EN];
   wire dig_off    = cfg_q[CFG_DIG_OFF];
   wire lf_off     = cfg_q[CFG_LF_OFF];
   wire long_en    = cfg_q[CFG_LONG_EN];
   wire retry_en   = cf2_q[CF2_RETRY];
   wire pwr_hold   = cf2_q[CF2_PWR_HOLD];
   wire lim_irq_en = cf2_q[CF2_LIMIT_IRQ];
   wire rf_only    = cf2_q[CF2_RF_ONLY];
   wire rf_off     = cf2_q[CF2_RF_OFF];
   wire cal_irq_en = cf2_q[CF2_CAL_IRQ];
   wire rel_sup    = cf2_q[CF2_REL_SUP];

   // ----------------------------------------------------------------------
   // Serial bus stall and idle watchdog
   // ----------------------------------------------------------------------
   logic [1:0] scl_sync_q, sda_sync_q;
   logic [$clog2(STALL_LOW+1)-1:0]  low_cnt_q;
   logic [$clog2(STALL_IDLE+1)-1:0] idle_cnt_q;
   logic bus_reset_q;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
      end else begin
         scl_sync_q <= {scl_sync_q[0], bus_clk_pin_in};
         sda_sync_q <= {sda_sync_q[0], bus_data_pin_in};
      end
   end
   wire scl_s = scl_sync_q[1];
   wire sda_s = sda_sync_q[1];
   wire low_hit  = low_cnt_q  == ($bits(low_cnt_q))'(STALL_LOW);
   wire idle_hit = idle_cnt_q == ($bits(idle_cnt_q))'(STALL_IDLE);

   // Counters saturate so one stall gives one reset pulse
   always_ff @(posedge clk_in) begin
      if (!rst_b_in || !stall_en) begin // RULE_06
         low_cnt_q   <= '0;
         idle_cnt_q  <= '0;
         bus_reset_q <= 1'b0;
      end else begin
         low_cnt_q  <= scl_s ? '0 : (low_hit ? low_cnt_q : low_cnt_q + 1'b1);
         idle_cnt_q <= !(scl_s && sda_s) ? '0 : (idle_hit ? idle_cnt_q : idle_cnt_q + 1'b1);
         bus_reset_q <= (!scl_s && low_cnt_q == ($bits(low_cnt_q))'(STALL_LOW - 1))          // RULE_04
                     || (scl_s && sda_s && idle_cnt_q == ($bits(idle_cnt_q))'(STALL_IDLE - 1)); // RULE_05
      end
   end
   assign bus_reset_out = bus_reset_q;

   // ----------------------------------------------------------------------
   // Per-channel noise blocking and recalibration policy
   // ----------------------------------------------------------------------
   logic [7:0] scaled_delta [NUM_CH];
   chan_out_s  chan_q       [NUM_CH];

   // Gain shift: 128x at code 0 down to 1x at code 7; shift code never used here
   genvar g;
   for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire [7:0] raw   = chan_in[g].raw_delta;
      wire [7:0] sh    = 8'($signed(raw) >>> gain_code); // RULE_01 RULE_03
      wire lf_block    = chan_in[g].lf_noise && !lf_off;  // RULE_09
      wire rf_block    = chan_in[g].rf_noise && !rf_off;  // RULE_17
      wire noise_band  = chan_in[g].above_noise_thr && !chan_in[g].above_touch_thr;
      wire sub_touch   = !chan_in[g].above_touch_thr;
      assign scaled_delta[g] = (lf_block || rf_block) ? 8'h00 : sh;

      always_ff @(posedge clk_in) begin
         if (!rst_b_in) begin
            chan_q[g] <= '0;
         end else begin
            chan_q[g].delta        <= scaled_delta[g];
            chan_q[g].noise_status <= chan_in[g].rf_noise
                                   || (chan_in[g].lf_noise && !rf_only);     // RULE_16
            chan_q[g].recal_feed   <= sub_touch && !(noise_band && !dig_off) // RULE_07 RULE_08
                                   && !lf_block && !rf_block;
            chan_q[g].long_recal   <= long_en && chan_in[g].touched
                                   && long_limit_hit_in[g];                  // RULE_10 RULE_11
            chan_q[g].retry_calib  <= retry_en && chan_in[g].enabled
                                   && chan_in[g].limit_out;                  // RULE_12 RULE_13
         end
      end
   end
   // Unpacked per-channel flops keep exactly one writer per element
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         chan_out[i] = chan_q[i];
      end
   end

   // ----------------------------------------------------------------------
   // Global flags and interrupt request
   // ----------------------------------------------------------------------
   logic [NUM_CH-1:0] lim_vec, cal_vec;
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         lim_vec[i] = chan_in[i].enabled && chan_in[i].limit_out;
         cal_vec[i] = chan_in[i].enabled && chan_in[i].calib_fail;
      end
   end
   wire lim_any = |lim_vec;
   wire cal_any = |cal_vec;
   logic irq_q;

   // Flags follow the enabled inputs; interrupt fires on their rising edge
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         limit_q <= 1'b0;
         calib_q <= 1'b0;
         irq_q   <= 1'b0;
      end else begin
         limit_q <= lim_any; // RULE_22
         calib_q <= cal_any;
         irq_q   <= (lim_irq_en && lim_any && !limit_q)   // RULE_15
                 || (cal_irq_en && cal_any && !calib_q)   // RULE_18
                 || press_evt_in || repeat_evt_in         // RULE_19 RULE_20
                 || (release_evt_in && !rel_sup);         // RULE_19 RULE_20
      end
   end
   assign irq_req_out    = irq_q;
   assign limit_flag_out = limit_q;
   assign calib_flag_out = calib_q;

   // ----------------------------------------------------------------------
   // Power saving between conversions and base count view
   // ----------------------------------------------------------------------
   logic lp_q;
   logic [BASE_W+7:0] base_q;
   wire [3:0] eff_shift = (shift_code > SHIFT_MAX_CODE) ? SHIFT_MAX_CODE : shift_code; // RULE_21

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         lp_q   <= 1'b0;
         base_q <= '0;
      end else begin
         if (cycle_end_in) lp_q <= 1'b0;
         else if (conv_done_in && !pwr_hold) lp_q <= 1'b1; // RULE_14
         else if (pwr_hold) lp_q <= 1'b0;                  // RULE_14
         base_q <= (BASE_W+8)'({8'h00, base_raw_in} << eff_shift); // RULE_02 RULE_03
      end
   end
   assign low_power_out = lp_q;
   assign base_view_out = base_q;

endmodule // touch_sense_global_config

//--- sim/serial_host_model.sv
// Host side of the two-wire serial bus, driving the clock and data pins.
// Assumes pulled-up lines, so a released line reads high.
`timescale 1ns/1ps
module serial_host_model (
   // Clock and mode: 0 released, 1 clock held low, 2 traffic
   input  wire logic       clk_in,
   input  wire logic [1:0] mode_in,
   // Bus pins
   output logic            bus_clk_out,
   output logic            bus_data_out
);
   logic [3:0] div_q = 4'h0;
   // Traffic keeps both-high spans at four cycles, below the bench idle limit of ten cycles
   always @(posedge clk_in) begin
      div_q        <= div_q + 4'h1;
      bus_clk_out  <= (mode_in == 2'd1) ? 1'b0 : (mode_in == 2'd0) ? 1'b1 : div_q[2];
      bus_data_out <= (mode_in == 2'd2) ? div_q[3] : 1'b1;
   end
endmodule // serial_host_model

//--- sim/tb.sv
// Self-checking bench for the touch configuration bank with a host pin model.
// Assumes the package, the bank and the checker bind are compiled first.
`timescale 1ns/1ps
module tb;
   import touch_cfg_pkg::*;
   // ---------------------------------------------------------------
   // Signals and model state
   // ---------------------------------------------------------------
   logic            clk_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic            bus_clk_pin_in, bus_data_pin_in, bus_reset_out, low_power_out;
   logic            irq_req_out, limit_flag_out, calib_flag_out;
   logic [1:0]      host_mode = 2'd2;
   logic [4:0]      ev = 5'h00;
   logic [7:0]      reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, long_limit_hit_in = 8'h00;
   logic [15:0]     base_raw_in = 16'h0000;
   logic [23:0]     base_view_out;
   chan_in_s [7:0]  chan_in = '0;
   chan_out_s [7:0] chan_out;
   logic [7:0]      addr_t [3] = '{ADDR_TOUCH_GAIN_CTRL, ADDR_GLOBAL_CONFIG, ADDR_GLOBAL_CONFIG_SEC};
   int              gain_m = 8'h2f, cfg_m = 8'h20, cf2_m = 8'h40, k;
   int              mismatches = 0, cmp_count = 0, irq_cnt = 0, rst_cnt = 0, seed = 32'h20f69b12;

   touch_sense_global_config #(.STALL_LOW(20), .STALL_IDLE(10)) touch_sense_global_config_i (.clk_in, .rst_b_in,
      .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .bus_clk_pin_in, .bus_data_pin_in,
      .bus_reset_out, .chan_in, .chan_out, .long_limit_hit_in, .press_evt_in(ev[0]), .release_evt_in(ev[1]),
      .repeat_evt_in(ev[2]), .base_raw_in, .base_view_out, .conv_done_in(ev[3]), .cycle_end_in(ev[4]),
      .low_power_out, .irq_req_out, .limit_flag_out, .calib_flag_out);
   serial_host_model serial_host_model_i (.clk_in, .mode_in(host_mode), .bus_clk_out(bus_clk_pin_in),
      .bus_data_out(bus_data_pin_in));

   initial forever #2 clk_in = ~clk_in;
   // Count pulses at the falling edge, where outputs have settled
   always @(negedge clk_in) begin
      if (irq_req_out === 1'b1) irq_cnt++;
      if (bus_reset_out === 1'b1) rst_cnt++;
   end
   initial begin
      #100000;
      mismatches++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // Model, compares and bus tasks
   // ---------------------------------------------------------------
   function automatic chan_out_s model_ch(input chan_in_s c, input logic hit);
      chan_out_s o;
      o.delta        = ((c.lf_noise && !cfg_m[4]) || (c.rf_noise && !cf2_m[2])) ? 8'h00 :
                       8'($signed(c.raw_delta) >>> gain_m[6:4]);
      o.noise_status = c.rf_noise || (c.lf_noise && !cf2_m[3]);
      o.recal_feed   = !c.above_touch_thr && !(c.above_noise_thr && !cfg_m[5])
                       && !(c.lf_noise && !cfg_m[4]) && !(c.rf_noise && !cf2_m[2]);
      o.long_recal   = hit && c.touched && cfg_m[3];
      o.retry_calib  = c.limit_out && cf2_m[6];
      return o;
   endfunction
   function automatic logic [7:0] mreg(input logic [7:0] a);
      return (a == ADDR_TOUCH_GAIN_CTRL) ? gain_m[7:0] : (a == ADDR_GLOBAL_CONFIG) ? cfg_m[7:0] : cf2_m[7:0];
   endfunction
   task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      chk_sig({24'h0, got}, {24'h0, exp});
   endtask
   task automatic chk_chan(input chan_out_s got, input chan_out_s exp);
      chk_sig({20'h0, got}, {20'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_in);
      reg_wr_in    <= 1'b0;
      if (a == ADDR_TOUCH_GAIN_CTRL) gain_m = d & 8'h7f;
      if (a == ADDR_GLOBAL_CONFIG) cfg_m = d & 8'hb8;
      if (a == ADDR_GLOBAL_CONFIG_SEC) cf2_m = d & 8'h7f;
      // Let an edge pass so a following write never re-drives the strobe in this step
      @(posedge clk_in);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clk_in);
      reg_rd_in   <= 1'b0;
      @(negedge clk_in);
      chk_reg(reg_rdata_out, exp);
      @(posedge clk_in);
   endtask
   task automatic pulse(input logic [4:0] e);
      ev <= e;
      @(posedge clk_in);
      ev <= 5'h00;
      @(negedge clk_in);
   endtask
   // Random channel reports; input 7 may be disabled and must not set flags
   task automatic chan_step();
      chan_in_s [7:0] nx;
      logic           lim, cal;
      int             sh;
      nx  = {$random(seed), $random(seed), $random(seed), $random(seed)};
      lim = 1'b0;
      cal = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < 7) nx[i].enabled = 1'b1;
         lim |= nx[i].limit_out & nx[i].enabled;
         cal |= nx[i].calib_fail & nx[i].enabled;
      end
      sh = (gain_m[3:0] > 8) ? 8 : gain_m[3:0];
      chan_in           <= nx;
      long_limit_hit_in <= 8'($random(seed));
      base_raw_in       <= 16'($random(seed));
      @(posedge clk_in);
      @(negedge clk_in);
      for (int i = 0; i < 8; i++) begin
         if (nx[i].enabled) chk_chan(chan_out[i], model_ch(nx[i], long_limit_hit_in[i]));
      end
      chk_sig({8'h00, base_view_out}, {8'h00, {8'h00, base_raw_in} << sh});
      @(posedge clk_in);
      rd_chk(ADDR_GLOBAL_STATUS, {1'b0, lim, cal, 5'h00});
   endtask
   task automatic stop_test();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      for (k = 0; k < 3; k++) rd_chk(addr_t[k], mreg(addr_t[k]));
      wr(8'h21, 8'hff);
      rd_chk(8'h21, 8'h00);
      repeat (30) begin
         for (k = 0; k < 3; k++) wr(addr_t[k], 8'($random(seed)));
         for (k = 0; k < 3; k++) rd_chk(addr_t[k], mreg(addr_t[k]));
         repeat (3) chan_step();
      end
      chan_in <= '0;
      for (k = 0; k < 6; k++) begin
         wr(ADDR_GLOBAL_CONFIG_SEC, (k > 2) ? 8'h01 : 8'h00);
         irq_cnt = 0;
         pulse(5'(1 << (k % 3)));
         repeat (3) @(posedge clk_in);
         chk_sig(irq_cnt, (k == 4) ? 0 : 1);
      end
      for (k = 0; k < 4; k++) begin
         wr(ADDR_GLOBAL_CONFIG_SEC, k[0] ? (k[1] ? 8'h02 : 8'h10) : 8'h00);
         irq_cnt = 0;
         chan_in[2] <= chan_in_s'(k[1] ? 16'h0003 : 16'h0005);
         repeat (6) @(posedge clk_in);
         chk_sig(irq_cnt, k & 1);
         chan_in[2] <= '0;
         repeat (3) @(posedge clk_in);
      end
      for (k = 0; k < 2; k++) begin
         wr(ADDR_GLOBAL_CONFIG_SEC, k ? 8'h20 : 8'h00);
         pulse(5'h08);
         chk_sig(low_power_out, k ? 0 : 1);
         @(posedge clk_in);
         pulse(5'h10);
         chk_sig(low_power_out, 0);
         @(posedge clk_in);
      end
      for (k = 0; k < 4; k++) begin
         wr(ADDR_GLOBAL_CONFIG, k[1] ? 8'h80 : 8'h00);
         rst_cnt = 0;
         host_mode <= k[0] ? 2'd0 : 2'd1;
         repeat (60) @(posedge clk_in);
         host_mode <= 2'd2;
         repeat (8) @(posedge clk_in);
         chk_sig(rst_cnt, k >> 1);
      end
      stop_test();
   end
endmodule // tb

//--- sim/touch_cfg_asserts.sv
// Port checks for the touch configuration bank.
// Assumes one clock domain; bound to every instance of the bank.
`timescale 1ns/1ps
module touch_cfg_asserts
   import touch_cfg_pkg::*;
#(
   parameter int BASE_W = 16
) (
   // Clock, reset and register port
   input wire logic              clk_in,
   input wire logic              rst_b_in,
   input wire logic [7:0]        reg_addr_in,
   input wire logic [7:0]        reg_wdata_in,
   input wire logic              reg_wr_in,
   input wire logic              reg_rd_in,
   input wire logic [7:0]        reg_rdata_out,
   // Events and results
   input wire logic              bus_reset_out,
   input wire logic              press_evt_in,
   input wire logic              release_evt_in,
   input wire logic              repeat_evt_in,
   input wire logic              irq_req_out,
   input wire logic              conv_done_in,
   input wire logic              cycle_end_in,
   input wire logic              low_power_out,
   input wire logic              limit_flag_out,
   input wire logic              calib_flag_out,
   input wire logic [BASE_W-1:0] base_raw_in,
   input wire logic [BASE_W+7:0] base_view_out
);
   // ---------------------------------------------------------------
   // Shadow registers
   // ---------------------------------------------------------------
   logic [7:0]        gain_q, cfg_q, cf2_q, rd_exp;
   logic [BASE_W+7:0] view_q;
   wire  [3:0]        shift_w = (gain_q[3:0] > 4'h8) ? 4'h8 : gain_q[3:0];
   assign rd_exp = (reg_addr_in == ADDR_TOUCH_GAIN_CTRL) ? gain_q : (reg_addr_in == ADDR_GLOBAL_CONFIG) ? cfg_q :
                   (reg_addr_in == ADDR_GLOBAL_CONFIG_SEC) ? cf2_q :
                   (reg_addr_in == ADDR_GLOBAL_STATUS) ? {1'b0, limit_flag_out, calib_flag_out, 5'h00} : 8'h00;
   // Track software writes so policy bits are known at every edge
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         gain_q <= 8'h2f;
         cfg_q  <= 8'h20;
         cf2_q  <= 8'h40;
         view_q <= '0;
      end else begin
         if (reg_wr_in && reg_addr_in == ADDR_TOUCH_GAIN_CTRL) gain_q <= reg_wdata_in & 8'h7f;
         if (reg_wr_in && reg_addr_in == ADDR_GLOBAL_CONFIG) cfg_q <= reg_wdata_in & 8'hb8;
         if (reg_wr_in && reg_addr_in == ADDR_GLOBAL_CONFIG_SEC) cf2_q <= reg_wdata_in & 8'h7f;
         view_q <= {8'h00, base_raw_in} << shift_w;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // Conversion end while power hold is clear
   sequence s_conv_idle;
      conv_done_in && !cycle_end_in && !cf2_q[CF2_PWR_HOLD];
   endsequence
   sequence s_hold_kept;
      cf2_q[CF2_PWR_HOLD] ##1 cf2_q[CF2_PWR_HOLD];
   endsequence
   rd_data_a: assert property (reg_rd_in |=> reg_rdata_out == $past(rd_exp))
      else $error("read data differs from register contents");
   press_irq_a: assert property (press_evt_in || repeat_evt_in |=> irq_req_out)
      else $error("press or repeat gave no interrupt");
   release_irq_a: assert property (release_evt_in && !cf2_q[CF2_REL_SUP] |=> irq_req_out)
      else $error("release gave no interrupt");
   stall_gate_a: assert property (bus_reset_out |-> cfg_q[CFG_STALL_EN] || $past(cfg_q[CFG_STALL_EN]))
      else $error("serial reset while stall reset disabled");
   low_pwr_set_a: assert property (s_conv_idle |=> low_power_out)
      else $error("no reduced power after conversion");
   low_pwr_end_a: assert property (cycle_end_in && !conv_done_in |=> !low_power_out)
      else $error("reduced power past cycle end");
   low_pwr_hold_a: assert property (s_hold_kept |-> !low_power_out)
      else $error("reduced power while hold set");
   base_view_a: assert property (base_view_out == view_q)
      else $error("base count presentation wrong");
   limit_irq_a: assert property ($rose(limit_flag_out) && $past(cf2_q[CF2_LIMIT_IRQ]) |-> ##[0:2] irq_req_out)
      else $error("limit flag gave no interrupt");
   calib_irq_a: assert property ($rose(calib_flag_out) && $past(cf2_q[CF2_CAL_IRQ]) |-> ##[0:2] irq_req_out)
      else $error("calibration flag gave no interrupt");
endmodule // touch_cfg_asserts

bind touch_sense_global_config touch_cfg_asserts #(.BASE_W(BASE_W)) chk_i (.clk_in, .rst_b_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .bus_reset_out, .press_evt_in, .release_evt_in,
   .repeat_evt_in, .irq_req_out, .conv_done_in, .cycle_end_in, .low_power_out, .limit_flag_out,
   .calib_flag_out, .base_raw_in, .base_view_out);
